// >>> shared/hpm_pkg.sv
// constants for the host-port mailbox and interrupt routing block
package hpm_pkg;

  // ==========================================================
  // on-chip register offsets
  localparam logic [15:0] HPM_OFS_MSG1 = 16'h0144;
  localparam logic [15:0] HPM_OFS_MSG2 = 16'h0148;
  localparam logic [15:0] HPM_OFS_MBX = 16'hC0C6;
  localparam logic [15:0] HPM_OFS_ROUTE = 16'hC0C8;
  localparam logic [15:0] HPM_OFS_MBX_IE = 16'hC0CA;

  // ==========================================================
  // routing register field positions
  localparam int HPM_BIT_OTG_ID_HP = 14;
  localparam int HPM_BIT_FM2_HP = 13;
  localparam int HPM_BIT_FM2_CPU = 12;
  localparam int HPM_BIT_FM1_HP = 11;
  localparam int HPM_BIT_FM1_CPU = 10;
  localparam int HPM_BIT_RST2_HP = 9;
  localparam int HPM_BIT_SWAP_HI = 8;
  localparam int HPM_BIT_RES2_HP = 7;
  localparam int HPM_BIT_RES1_HP = 6;
  localparam int HPM_BIT_TRANSFER_DONE_IRQ_2_HP = 3;
  localparam int HPM_BIT_TRANSFER_DONE_IRQ_1_HP = 2;
  localparam int HPM_BIT_RST1_HP = 1;
  localparam int HPM_BIT_SWAP_LO = 0;
  localparam logic [15:0] HPM_ROUTE_WMASK = 16'h7FCF;

  // ==========================================================
  // mailbox interrupt enable field positions
  localparam int HPM_BIT_IE_RXF = 0;
  localparam int HPM_BIT_IE_TXE = 1;

  // ==========================================================
  // host-port select codes and status word layout
  localparam logic [1:0] HPM_HP_SEL_MBX = 2'h0;
  localparam logic [1:0] HPM_HP_SEL_MSG1 = 2'h1;
  localparam logic [1:0] HPM_HP_SEL_MSG2 = 2'h2;
  localparam logic [1:0] HPM_HP_SEL_STATUS = 2'h3;
  localparam int HPM_ST_MSG1 = 0;
  localparam int HPM_ST_MSG2 = 1;
  localparam int HPM_ST_NOTE = 2;
  localparam int HPM_ST_RXF = 3;
  localparam int HPM_ST_TXE = 4;

  // ==========================================================
  // reset values
  localparam logic [15:0] HPM_ROUTE_RST = 16'h0000;
  localparam logic [15:0] HPM_MBX_RST = 16'h0000;
  localparam logic [1:0] HPM_IE_RST = 2'h0;
  localparam logic HPM_MSG_FLAG_RST = 1'b1;
  localparam logic HPM_FLAG_RST = 1'b0;

  // ==========================================================
  // host-side settle time after reset before trusting the interrupt
  localparam int HPM_HOST_CLEAR_MS = 10;

endpackage

// >>> verilog/hpm_flag.sv
// sticky event flag with set priority over clear
`timescale 1ns/1ps
module hpm_flag #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_set,
  input wire logic i_clr,
  output logic o_flag
);

  logic flag_r;
  logic flag_nxt;

  // ==========================================================
  // next value: a set in the clearing cycle is kept
  assign flag_nxt = i_set | (flag_r & ~i_clr);

  // flag storage
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      flag_r <= RST_VAL;
    end
    else
    begin
      flag_r <= flag_nxt;
    end
  end

  assign o_flag = flag_r;

endmodule // hpm_flag

// >>> verilog/hpm_host_port_mailbox.sv
// host-port interrupt routing, message flags and shared mailbox
`timescale 1ns/1ps
module hpm_host_port_mailbox (
  input wire logic i_clock,
  input wire logic i_rst,
  // on-chip cpu register port
  input wire logic [15:0] i_cpu_addr,
  input wire logic i_cpu_wr,
  input wire logic i_cpu_rd,
  input wire logic [15:0] i_cpu_wdata,
  output logic [15:0] o_cpu_rdata,
  // external host port
  input wire logic [1:0] i_hp_sel,
  input wire logic i_hp_wr,
  input wire logic i_hp_rd,
  input wire logic [15:0] i_host_port_data_bus_in,
  output logic [15:0] o_host_port_data_bus_out,
  output logic o_host_port_data_bus_oe,
  output logic o_host_irq_out,
  // interrupt sources from the serial engines
  input wire logic i_otg_id_irq,
  input wire logic i_frame_marker_irq_1,
  input wire logic i_frame_marker_irq_2,
  input wire logic i_bus_reset_irq_1,
  input wire logic i_bus_reset_irq_2,
  input wire logic i_resume_irq_1,
  input wire logic i_resume_irq_2,
  input wire logic i_transfer_done_irq_1,
  input wire logic i_transfer_done_irq_2,
  // interrupts toward the on-chip cpu
  output logic o_cpu_otg_id_irq,
  output logic o_cpu_frame_marker_irq_1,
  output logic o_cpu_frame_marker_irq_2,
  output logic o_cpu_bus_reset_irq_1,
  output logic o_cpu_bus_reset_irq_2,
  output logic o_cpu_resume_irq_1,
  output logic o_cpu_resume_irq_2,
  output logic o_cpu_transfer_done_irq_1,
  output logic o_cpu_transfer_done_irq_2,
  output logic o_cpu_mbx_rx_full_irq,
  output logic o_cpu_mbx_tx_empty_irq
);

  // ==========================================================
  // storage
  logic [15:0] route_r;
  logic [15:0] route_nxt;
  logic [15:0] mbx_r;
  logic [15:0] mbx_nxt;
  logic [1:0] ie_r;
  logic [1:0] ie_nxt;
  logic [15:0] cpu_rdata_r;
  logic [15:0] cpu_rdata_nxt;
  logic [15:0] hp_dout_r;
  logic [15:0] hp_dout_nxt;
  logic hp_oe_r;
  logic host_irq_r;
  logic host_irq_nxt;
  logic [8:0] cpu_irq_r;
  logic [8:0] cpu_irq_nxt;
  logic [1:0] mbx_irq_r;
  logic [1:0] mbx_irq_nxt;

  // ==========================================================
  // cpu address decode
  logic cpu_hit_msg1;
  logic cpu_hit_msg2;
  logic cpu_hit_mbx;
  logic cpu_hit_route;
  logic cpu_hit_ie;

  assign cpu_hit_msg1 = (i_cpu_addr == hpm_pkg::HPM_OFS_MSG1);
  assign cpu_hit_msg2 = (i_cpu_addr == hpm_pkg::HPM_OFS_MSG2);
  assign cpu_hit_mbx = (i_cpu_addr == hpm_pkg::HPM_OFS_MBX);
  assign cpu_hit_route = (i_cpu_addr == hpm_pkg::HPM_OFS_ROUTE);
  assign cpu_hit_ie = (i_cpu_addr == hpm_pkg::HPM_OFS_MBX_IE);

  // ==========================================================
  // host port select decode
  logic hp_hit_mbx;
  logic hp_hit_msg1;
  logic hp_hit_msg2;

  assign hp_hit_mbx = (i_hp_sel == hpm_pkg::HPM_HP_SEL_MBX);
  assign hp_hit_msg1 = (i_hp_sel == hpm_pkg::HPM_HP_SEL_MSG1);
  assign hp_hit_msg2 = (i_hp_sel == hpm_pkg::HPM_HP_SEL_MSG2);

  // ==========================================================
  // byte lane swap, active only when both bits agree at one
  logic swap_on;
  logic [15:0] hp_din;

  assign swap_on = route_r[hpm_pkg::HPM_BIT_SWAP_HI] &
                   route_r[hpm_pkg::HPM_BIT_SWAP_LO];
  assign hp_din = swap_on ? {i_host_port_data_bus_in[7:0], i_host_port_data_bus_in[15:8]}
                          : i_host_port_data_bus_in;

  // ==========================================================
  // message flags: only the write event is kept, data is dropped
  logic msg1_flag;
  logic msg2_flag;
  logic msg1_set;
  logic msg2_set;
  logic msg1_clr;
  logic msg2_clr;

  assign msg1_set = i_cpu_wr & cpu_hit_msg1;
  assign msg2_set = i_cpu_wr & cpu_hit_msg2;
  assign msg1_clr = i_hp_rd & hp_hit_msg1;
  assign msg2_clr = i_hp_rd & hp_hit_msg2;

  // flags come up pending, mirroring the stray power-up content
  hpm_flag #(
    .RST_VAL(hpm_pkg::HPM_MSG_FLAG_RST)
  ) u_msg1_flag (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_set(msg1_set),
    .i_clr(msg1_clr),
    .o_flag(msg1_flag)
  );

  hpm_flag #(
    .RST_VAL(hpm_pkg::HPM_MSG_FLAG_RST)
  ) u_msg2_flag (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_set(msg2_set),
    .i_clr(msg2_clr),
    .o_flag(msg2_flag)
  );

  // ==========================================================
  // mailbox handshake flags
  logic mbx_host_wr;
  logic mbx_host_rd;
  logic mbx_cpu_wr;
  logic mbx_cpu_rd;
  logic rx_full;
  logic tx_empty;
  logic host_note;

  assign mbx_host_wr = i_hp_wr & hp_hit_mbx;
  assign mbx_host_rd = i_hp_rd & hp_hit_mbx;
  assign mbx_cpu_wr = i_cpu_wr & cpu_hit_mbx;
  assign mbx_cpu_rd = i_cpu_rd & cpu_hit_mbx;

  // receive full: host writes, cpu read acknowledges
  hpm_flag #(
    .RST_VAL(hpm_pkg::HPM_FLAG_RST)
  ) u_rx_full (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_set(mbx_host_wr),
    .i_clr(mbx_cpu_rd),
    .o_flag(rx_full)
  );

  // transmit empty: host reads, cpu write acknowledges
  hpm_flag #(
    .RST_VAL(hpm_pkg::HPM_FLAG_RST)
  ) u_tx_empty (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_set(mbx_host_rd),
    .i_clr(mbx_cpu_wr),
    .o_flag(tx_empty)
  );

  // host notice: cpu writes, host read acknowledges
  hpm_flag #(
    .RST_VAL(hpm_pkg::HPM_FLAG_RST)
  ) u_host_note (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_set(mbx_cpu_wr),
    .i_clr(mbx_host_rd),
    .o_flag(host_note)
  );

  // ==========================================================
  // register write paths
  assign route_nxt = (i_cpu_wr & cpu_hit_route) ? (i_cpu_wdata & hpm_pkg::HPM_ROUTE_WMASK)
                                                : route_r;
  assign ie_nxt = (i_cpu_wr & cpu_hit_ie) ? i_cpu_wdata[1:0] : ie_r;
  // host write wins over a cpu write in the same cycle
  assign mbx_nxt = mbx_host_wr ? hp_din :
                   mbx_cpu_wr ? i_cpu_wdata : mbx_r;

  // ==========================================================
  // cpu read mux, unmapped and write-only locations read zero
  assign cpu_rdata_nxt = !i_cpu_rd ? cpu_rdata_r :
                         cpu_hit_mbx ? mbx_r :
                         cpu_hit_route ? route_r :
                         cpu_hit_ie ? {14'h0000, ie_r} : 16'h0000;

  // ==========================================================
  // host read mux, swapped onto the lanes as selected
  logic [15:0] hp_status;
  logic [15:0] hp_word;

  assign hp_status = {11'h000, tx_empty, rx_full, host_note, msg2_flag, msg1_flag};
  assign hp_word = hp_hit_mbx ? mbx_r :
                   (i_hp_sel == hpm_pkg::HPM_HP_SEL_STATUS) ? hp_status : 16'h0000;
  assign hp_dout_nxt = !i_hp_rd ? hp_dout_r :
                       swap_on ? {hp_word[7:0], hp_word[15:8]} : hp_word;

  // ==========================================================
  // interrupt routing toward the host port
  logic [8:0] to_host;

  assign to_host[0] = i_otg_id_irq & route_r[hpm_pkg::HPM_BIT_OTG_ID_HP];
  assign to_host[1] = i_frame_marker_irq_2 & route_r[hpm_pkg::HPM_BIT_FM2_HP];
  assign to_host[2] = i_frame_marker_irq_1 & route_r[hpm_pkg::HPM_BIT_FM1_HP];
  assign to_host[3] = i_bus_reset_irq_2 & route_r[hpm_pkg::HPM_BIT_RST2_HP];
  assign to_host[4] = i_bus_reset_irq_1 & route_r[hpm_pkg::HPM_BIT_RST1_HP];
  assign to_host[5] = i_resume_irq_2 & route_r[hpm_pkg::HPM_BIT_RES2_HP];
  assign to_host[6] = i_resume_irq_1 & route_r[hpm_pkg::HPM_BIT_RES1_HP];
  assign to_host[7] = i_transfer_done_irq_2 & route_r[hpm_pkg::HPM_BIT_TRANSFER_DONE_IRQ_2_HP];
  assign to_host[8] = i_transfer_done_irq_1 & route_r[hpm_pkg::HPM_BIT_TRANSFER_DONE_IRQ_1_HP];

  // ==========================================================
  // interrupt routing toward the on-chip cpu
  assign cpu_irq_nxt[0] = i_otg_id_irq & ~route_r[hpm_pkg::HPM_BIT_OTG_ID_HP];
  assign cpu_irq_nxt[1] = i_frame_marker_irq_2 & route_r[hpm_pkg::HPM_BIT_FM2_CPU];
  assign cpu_irq_nxt[2] = i_frame_marker_irq_1 & route_r[hpm_pkg::HPM_BIT_FM1_CPU];
  assign cpu_irq_nxt[3] = i_bus_reset_irq_2 & ~route_r[hpm_pkg::HPM_BIT_RST2_HP];
  assign cpu_irq_nxt[4] = i_bus_reset_irq_1 & ~route_r[hpm_pkg::HPM_BIT_RST1_HP];
  assign cpu_irq_nxt[5] = i_resume_irq_2 & ~route_r[hpm_pkg::HPM_BIT_RES2_HP];
  assign cpu_irq_nxt[6] = i_resume_irq_1 & ~route_r[hpm_pkg::HPM_BIT_RES1_HP];
  assign cpu_irq_nxt[7] = i_transfer_done_irq_2 & ~route_r[hpm_pkg::HPM_BIT_TRANSFER_DONE_IRQ_2_HP];
  assign cpu_irq_nxt[8] = i_transfer_done_irq_1 & ~route_r[hpm_pkg::HPM_BIT_TRANSFER_DONE_IRQ_1_HP];

  // mailbox interrupts gated by their enables
  assign mbx_irq_nxt[0] = rx_full & ie_r[hpm_pkg::HPM_BIT_IE_RXF];
  assign mbx_irq_nxt[1] = tx_empty & ie_r[hpm_pkg::HPM_BIT_IE_TXE];

  // ==========================================================
  // combined host interrupt
  assign host_irq_nxt = msg1_flag | msg2_flag | host_note | (|to_host);

  // ==========================================================
  // control registers
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      route_r <= hpm_pkg::HPM_ROUTE_RST;
      ie_r <= hpm_pkg::HPM_IE_RST;
      mbx_r <= hpm_pkg::HPM_MBX_RST;
    end
    else
    begin
      route_r <= route_nxt;
      ie_r <= ie_nxt;
      mbx_r <= mbx_nxt;
    end
  end

  // ==========================================================
  // output registers
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      cpu_rdata_r <= 16'h0000;
      hp_dout_r <= 16'h0000;
      hp_oe_r <= 1'b0;
      host_irq_r <= 1'b0;
      cpu_irq_r <= 9'h000;
      mbx_irq_r <= 2'h0;
    end
    else
    begin
      cpu_rdata_r <= cpu_rdata_nxt;
      hp_dout_r <= hp_dout_nxt;
      hp_oe_r <= i_hp_rd; // drive lanes one cycle per read
      host_irq_r <= host_irq_nxt;
      cpu_irq_r <= cpu_irq_nxt;
      mbx_irq_r <= mbx_irq_nxt;
    end
  end

  // ==========================================================
  // port assignments
  assign o_cpu_rdata = cpu_rdata_r;
  assign o_host_port_data_bus_out = hp_dout_r;
  assign o_host_port_data_bus_oe = hp_oe_r;
  assign o_host_irq_out = host_irq_r;
  assign o_cpu_otg_id_irq = cpu_irq_r[0];
  assign o_cpu_frame_marker_irq_2 = cpu_irq_r[1];
  assign o_cpu_frame_marker_irq_1 = cpu_irq_r[2];
  assign o_cpu_bus_reset_irq_2 = cpu_irq_r[3];
  assign o_cpu_bus_reset_irq_1 = cpu_irq_r[4];
  assign o_cpu_resume_irq_2 = cpu_irq_r[5];
  assign o_cpu_resume_irq_1 = cpu_irq_r[6];
  assign o_cpu_transfer_done_irq_2 = cpu_irq_r[7];
  assign o_cpu_transfer_done_irq_1 = cpu_irq_r[8];
  assign o_cpu_mbx_rx_full_irq = mbx_irq_r[0];
  assign o_cpu_mbx_tx_empty_irq = mbx_irq_r[1];

endmodule // hpm_host_port_mailbox

// >>> bench/hpm_asserts.sv
// concurrent checks on the host-port mailbox block ports
`timescale 1ns/1ps
module hpm_asserts (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [15:0] i_cpu_addr,
  input wire logic i_cpu_wr,
  input wire logic i_cpu_rd,
  input wire logic [15:0] i_cpu_wdata,
  input wire logic [1:0] i_hp_sel,
  input wire logic i_hp_wr,
  input wire logic i_hp_rd,
  input wire logic o_host_irq_out,
  input wire logic i_otg_id_irq,
  input wire logic i_frame_marker_irq_1,
  input wire logic i_frame_marker_irq_2,
  input wire logic i_bus_reset_irq_1,
  input wire logic o_cpu_otg_id_irq,
  input wire logic o_cpu_frame_marker_irq_1,
  input wire logic o_cpu_frame_marker_irq_2,
  input wire logic o_cpu_bus_reset_irq_1,
  input wire logic o_cpu_mbx_rx_full_irq,
  input wire logic o_cpu_mbx_tx_empty_irq
);
  logic [15:0] rt_r;
  // ==========================================================
  // shadow of the routing register, tracked from cpu writes
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      rt_r <= 16'h0000;
    else if (i_cpu_wr && i_cpu_addr == hpm_pkg::HPM_OFS_ROUTE)
      rt_r <= i_cpu_wdata & hpm_pkg::HPM_ROUTE_WMASK;
  end
  // mailbox accesses from either side
  wire mbx_cw = i_cpu_wr && i_cpu_addr == hpm_pkg::HPM_OFS_MBX;
  wire mbx_cr = i_cpu_rd && i_cpu_addr == hpm_pkg::HPM_OFS_MBX;
  wire mbx_hw = i_hp_wr && i_hp_sel == hpm_pkg::HPM_HP_SEL_MBX;
  wire mbx_hr = i_hp_rd && i_hp_sel == hpm_pkg::HPM_HP_SEL_MBX;
  wire msg_cw = i_cpu_wr && (i_cpu_addr == hpm_pkg::HPM_OFS_MSG1
    || i_cpu_addr == hpm_pkg::HPM_OFS_MSG2);
  default clocking @(posedge i_clock);
  endclocking
  default disable iff (i_rst);
  // ==========================================================
  // assertions
  AST_MSG_IRQ: assert property (msg_cw |-> ##2 o_host_irq_out)
    else $error("message write did not raise host irq");
  AST_OTG: assert property (o_cpu_otg_id_irq == $past(i_otg_id_irq && !rt_r[14]))
    else $error("otg id cpu routing wrong");
  AST_FM2: assert property (o_cpu_frame_marker_irq_2 == $past(i_frame_marker_irq_2 && rt_r[12]))
    else $error("frame marker 2 cpu routing wrong");
  AST_FM1: assert property (o_cpu_frame_marker_irq_1 == $past(i_frame_marker_irq_1 && rt_r[10]))
    else $error("frame marker 1 cpu routing wrong");
  AST_RST1: assert property (o_cpu_bus_reset_irq_1 == $past(i_bus_reset_irq_1 && !rt_r[1]))
    else $error("bus reset 1 cpu routing wrong");
  AST_RXF: assert property (mbx_cr && !mbx_hw ##1 !mbx_hw |=> !o_cpu_mbx_rx_full_irq)
    else $error("rx full not cleared by cpu read");
  AST_TXE: assert property (mbx_cw && !mbx_hr ##1 !mbx_hr |=> !o_cpu_mbx_tx_empty_irq)
    else $error("tx empty not cleared by cpu write");
  AST_NOTE: assert property (mbx_cw |-> ##2 o_host_irq_out)
    else $error("mailbox write did not raise host irq");
endmodule // hpm_asserts

bind hpm_host_port_mailbox hpm_asserts hpm_asserts_i (.*);

// >>> bench/hpm_host_model.sv
// behavioural external host processor on the host port
`timescale 1ns/1ps
module hpm_host_model (
  input wire logic i_clock,
  input wire logic [15:0] i_data,
  input wire logic i_oe,
  output logic [1:0] o_sel,
  output logic o_wr,
  output logic o_rd,
  output logic [15:0] o_data
);
  // idle bus at time zero
  initial
  begin
    o_sel = 2'h0;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_data = 16'h0000;
  end
  // one-cycle write; released lanes show the inverse value
  task automatic hp_write(input logic [1:0] sel, input logic [15:0] d);
    @(negedge i_clock);
    o_sel = sel;
    o_data = d;
    o_wr = 1'b1;
    @(negedge i_clock);
    o_wr = 1'b0;
    o_data = ~d;
  endtask
  // one-cycle read; a mailbox read is the acknowledge
  task automatic hp_read(input logic [1:0] sel, output logic [15:0] d, output logic oe);
    @(negedge i_clock);
    o_sel = sel;
    o_rd = 1'b1;
    @(negedge i_clock);
    o_rd = 1'b0;
    d = i_data;
    oe = i_oe;
  endtask
  // drops both pending messages left from power-up
  task automatic power_up_clear;
    logic [15:0] d;
    logic e;
    hp_read(hpm_pkg::HPM_HP_SEL_MSG1, d, e);
    hp_read(hpm_pkg::HPM_HP_SEL_MSG2, d, e);
  endtask
endmodule // hpm_host_model

// >>> bench/tb.sv
// self-checking testbench for the host-port mailbox block
`timescale 1ns/1ps
module tb;
  logic i_clock;
  logic i_rst;
  logic [15:0] cpu_addr;
  logic [15:0] cpu_wdata;
  logic cpu_wr;
  logic cpu_rd;
  logic [8:0] src;
  logic [15:0] rd;
  logic [15:0] r;
  logic oe;
  wire [15:0] cpu_rdata;
  wire [15:0] hp_dout;
  wire [15:0] hp_din;
  wire [1:0] hp_sel;
  wire hp_wr;
  wire hp_rd;
  wire hp_oe;
  wire irq;
  wire rxf;
  wire txe;
  wire [8:0] cpu_v;
  int fail_count = 0;
  int cmp_count = 0;
  int hb[9] = '{14, 11, 13, 1, 9, 6, 7, 2, 3};
  int cb[9] = '{5, 10, 12, 5, 5, 5, 5, 5, 5};
  // ==========================================================
  // design and host model
  hpm_host_port_mailbox hpm_host_port_mailbox_i (.i_clock(i_clock), .i_rst(i_rst),
    .i_cpu_addr(cpu_addr), .i_cpu_wr(cpu_wr), .i_cpu_rd(cpu_rd), .i_cpu_wdata(cpu_wdata),
    .o_cpu_rdata(cpu_rdata), .i_hp_sel(hp_sel), .i_hp_wr(hp_wr), .i_hp_rd(hp_rd),
    .i_host_port_data_bus_in(hp_din), .o_host_port_data_bus_out(hp_dout),
    .o_host_port_data_bus_oe(hp_oe), .o_host_irq_out(irq), .i_otg_id_irq(src[0]),
    .i_frame_marker_irq_1(src[1]), .i_frame_marker_irq_2(src[2]), .i_bus_reset_irq_1(src[3]),
    .i_bus_reset_irq_2(src[4]), .i_resume_irq_1(src[5]), .i_resume_irq_2(src[6]),
    .i_transfer_done_irq_1(src[7]), .i_transfer_done_irq_2(src[8]),
    .o_cpu_otg_id_irq(cpu_v[0]), .o_cpu_frame_marker_irq_1(cpu_v[1]),
    .o_cpu_frame_marker_irq_2(cpu_v[2]), .o_cpu_bus_reset_irq_1(cpu_v[3]),
    .o_cpu_bus_reset_irq_2(cpu_v[4]), .o_cpu_resume_irq_1(cpu_v[5]),
    .o_cpu_resume_irq_2(cpu_v[6]), .o_cpu_transfer_done_irq_1(cpu_v[7]),
    .o_cpu_transfer_done_irq_2(cpu_v[8]), .o_cpu_mbx_rx_full_irq(rxf),
    .o_cpu_mbx_tx_empty_irq(txe));
  hpm_host_model hpm_host_model_i (.i_clock(i_clock), .i_data(hp_dout), .i_oe(hp_oe),
    .o_sel(hp_sel), .o_wr(hp_wr), .o_rd(hp_rd), .o_data(hp_din));
  // ==========================================================
  // clock, watchdog and helper tasks
  initial
  begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  initial
  begin
    #100000;
    fail_count++;
    stop_test();
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    chk({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic cw(input logic [15:0] a, input logic [15:0] d);
    @(negedge i_clock);
    cpu_addr = a;
    cpu_wdata = d;
    cpu_wr = 1'b1;
    @(negedge i_clock);
    cpu_wr = 1'b0;
  endtask
  task automatic cr(input logic [15:0] a, output logic [15:0] d);
    @(negedge i_clock);
    cpu_addr = a;
    cpu_rd = 1'b1;
    @(negedge i_clock);
    cpu_rd = 1'b0;
    d = cpu_rdata;
  endtask
  task automatic settle;
    repeat (3) @(negedge i_clock);
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial
  begin
    i_rst = 1'b1;
    cpu_addr = 16'h0000;
    cpu_wdata = 16'h0000;
    cpu_wr = 1'b0;
    cpu_rd = 1'b0;
    src = 9'h000;
    repeat (6) @(negedge i_clock);
    i_rst = 1'b0;
    settle();
    chkb(irq, 1'b1);
    hpm_host_model_i.hp_read(hpm_pkg::HPM_HP_SEL_STATUS, rd, oe);
    chk(rd, 16'h0003);
    chkb(oe, 1'b1);
    cr(hpm_pkg::HPM_OFS_ROUTE, rd);
    chk(rd, 16'h0000);
    cr(hpm_pkg::HPM_OFS_MBX, rd);
    chk(rd, 16'h0000);
    hpm_host_model_i.power_up_clear();
    settle();
    chkb(irq, 1'b0);
    $display("test reset done");
    // message locations, contents ignored
    for (int i = 0; i < 2; i++)
    begin
      cw(i ? hpm_pkg::HPM_OFS_MSG2 : hpm_pkg::HPM_OFS_MSG1, i ? 16'hFFFF : 16'h0000);
      cr(i ? hpm_pkg::HPM_OFS_MSG2 : hpm_pkg::HPM_OFS_MSG1, rd);
      chk(rd, 16'h0000);
      settle();
      chkb(irq, 1'b1);
      hpm_host_model_i.hp_read(hpm_pkg::HPM_HP_SEL_STATUS, rd, oe);
      chk(rd, 16'h0001 << i);
      hpm_host_model_i.hp_read(i ? hpm_pkg::HPM_HP_SEL_MSG2 : hpm_pkg::HPM_HP_SEL_MSG1, rd, oe);
      settle();
      chkb(irq, 1'b0);
    end
    $display("test messages done");
    // mailbox in both directions
    cw(hpm_pkg::HPM_OFS_MBX_IE, 16'h0003);
    cw(hpm_pkg::HPM_OFS_MBX, 16'h1234);
    settle();
    chkb(irq, 1'b1);
    hpm_host_model_i.hp_read(hpm_pkg::HPM_HP_SEL_MBX, rd, oe);
    chk(rd, 16'h1234);
    settle();
    chkb(irq, 1'b0);
    chkb(txe, 1'b1);
    cw(hpm_pkg::HPM_OFS_MBX, 16'hBEEF);
    settle();
    chkb(txe, 1'b0);
    hpm_host_model_i.hp_read(hpm_pkg::HPM_HP_SEL_MBX, rd, oe);
    chk(rd, 16'hBEEF);
    hpm_host_model_i.hp_write(hpm_pkg::HPM_HP_SEL_MBX, 16'hA5C3);
    settle();
    chkb(rxf, 1'b1);
    cr(hpm_pkg::HPM_OFS_MBX, rd);
    chk(rd, 16'hA5C3);
    settle();
    chkb(rxf, 1'b0);
    // enables off: flags still set in the status word, no cpu interrupt
    cw(hpm_pkg::HPM_OFS_MBX_IE, 16'h0000);
    hpm_host_model_i.hp_write(hpm_pkg::HPM_HP_SEL_MBX, 16'h0F0F);
    settle();
    chkb(rxf, 1'b0);
    chkb(txe, 1'b0);
    hpm_host_model_i.hp_read(hpm_pkg::HPM_HP_SEL_STATUS, rd, oe);
    chk(rd, (16'h0001 << hpm_pkg::HPM_ST_RXF) | (16'h0001 << hpm_pkg::HPM_ST_TXE));
    cr(hpm_pkg::HPM_OFS_MBX, rd);
    chk(rd, 16'h0F0F);
    $display("test mailbox done");
    // byte-lane exchange and reserved route bits
    cw(hpm_pkg::HPM_OFS_ROUTE, 16'h0101);
    hpm_host_model_i.hp_write(hpm_pkg::HPM_HP_SEL_MBX, 16'h1234);
    cr(hpm_pkg::HPM_OFS_MBX, rd);
    chk(rd, 16'h3412);
    hpm_host_model_i.hp_read(hpm_pkg::HPM_HP_SEL_MBX, rd, oe);
    chk(rd, 16'h1234);
    cw(hpm_pkg::HPM_OFS_ROUTE, 16'hFFFF);
    cr(hpm_pkg::HPM_OFS_ROUTE, rd);
    chk(rd, 16'h7FCF);
    $display("test swap done");
    // every source under no and host routing, and host-plus-cpu routing for the two frame markers
    for (int k = 0; k < 9; k++)
    begin
      src = 9'h001 << k;
      for (int j = 0; j < 3; j++)
      begin
        r = (j == 0) ? 16'h0000 : 16'h0001 << hb[k];
        if (j == 2)
          r = r | (16'h0001 << cb[k]);
        cw(hpm_pkg::HPM_OFS_ROUTE, r);
        settle();
        chkb(cpu_v[k], (k == 1 || k == 2) ? r[cb[k]] : !r[hb[k]]);
        chkb(irq, r[hb[k]]);
      end
    end
    src = 9'h000;
    $display("test routing done");
    // second reset in mid-run: flags pending again, registers back to zero
    @(negedge i_clock);
    i_rst = 1'b1;
    repeat (2) @(negedge i_clock);
    i_rst = 1'b0;
    settle();
    chkb(irq, 1'b1);
    cr(hpm_pkg::HPM_OFS_MBX, rd);
    chk(rd, 16'h0000);
    cr(hpm_pkg::HPM_OFS_ROUTE, rd);
    chk(rd, 16'h0000);
    $display("test second reset done");
    stop_test();
  end
endmodule // tb
